// ---- logic/wcd_watchdog.sv ----
/*
 Watchdog timer driven by the nonvolatile configuration word, with an APB register slave.
 Assumes configWord is stable from reset and the two RC oscillators arrive as async pins.
*/
`timescale 1ns/1ps

// Functional notes
// - The watchdog runs when the enable fuse bit is 1 and stays stopped when it is 0.
// - Run clock code 11 picks the low-power RC, 10 the fast RC, 00 the system clock, 01 is reserved.
// - The postscale code selects a divide ratio of two to the code, 1:1 at 00000 up to 1:524288 at 10011.
// - Postscale codes 10100 through 11111 all saturate at 1:1048576.
// - Window disable 0 gives windowed mode and 1 gives non-windowed mode.
// - Fields sit at enable 15, clock 14-13, postscale 12-8, window disable 7, size 6-5, sleep 4-0.
module wcd_watchdog
	import wcd_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [31:0] configWord,
	input wire logic lowPowerRcPin,
	input wire logic fastRcPin,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic timeoutPulse,
	output logic watchdogRunning
);
	function automatic logic [19:0] termOf(input logic [4:0] code);
		if (code >= WCD_POST_SAT_CODE)
			return WCD_TERM_MAX;
		return 20'((21'h1 << code) - 21'h1);
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		return a == WCD_OFS_CONFIG || a == WCD_OFS_SERVICE || a == WCD_OFS_STATUS || a == WCD_OFS_COUNT;
	endfunction

	// Rising edge once stages two and three agree on high and the held level was low
	function automatic logic risenOf(input logic [2:0] sync, input logic level);
		return sync[2] & sync[1] & ~level;
	endfunction

	logic [1:0] rstPipe_reg;
	logic rstSync_n;
	wcd_cfg_t cfg_reg;
	logic cfgLoaded_reg;
	logic [2:0] lpSync_reg;
	logic [2:0] frSync_reg;
	logic lpLevel_reg;
	logic frLevel_reg;
	logic srcTick;
	logic [19:0] terminal;
	logic [19:0] postCount_reg;
	logic service;
	logic early;
	logic expire;
	wcd_status_t status_reg;
	logic timeout_reg;
	logic [31:0] prdata_reg;
	logic [31:0] readData;
	logic wrAccess;

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			rstPipe_reg <= 2'h0;
		else
			rstPipe_reg <= {rstPipe_reg[0], 1'b1};
	end
	assign rstSync_n = rstPipe_reg[1];

	// Configuration captured once after reset release
	always_ff @(posedge clock or negedge rstSync_n)
	begin
		if (!rstSync_n)
		begin
			cfg_reg <= '0;
			cfgLoaded_reg <= 1'b0;
		end
		else if (!cfgLoaded_reg)
		begin
			cfg_reg.watchdogEnableFuse <= configWord[WCD_POS_ENABLE];
			cfg_reg.runClockSourceSelect <= configWord[WCD_POS_RUNCLK_HI:WCD_POS_RUNCLK_LO];
			cfg_reg.runPostscaleSelect <= configWord[WCD_POS_RUNPOST_HI:WCD_POS_RUNPOST_LO];
			cfg_reg.windowModeDisable <= configWord[WCD_POS_WINDOW_MODE_DISABLE];
			cfg_reg.windowSizeSelect <= configWord[WCD_POS_WINSIZE_HI:WCD_POS_WINSIZE_LO];
			cfg_reg.sleepPostscaleSelect <= configWord[WCD_POS_SLPPOST_HI:WCD_POS_SLPPOST_LO];
			cfgLoaded_reg <= 1'b1;
		end
	end

	// Three-stage pin synchronisers for the RC oscillators
	always_ff @(posedge clock or negedge rstSync_n)
	begin
		if (!rstSync_n)
		begin
			lpSync_reg <= 3'h0;
			frSync_reg <= 3'h0;
			lpLevel_reg <= 1'b0;
			frLevel_reg <= 1'b0;
		end
		else
		begin
			lpSync_reg <= {lpSync_reg[1:0], lowPowerRcPin};
			frSync_reg <= {frSync_reg[1:0], fastRcPin};
			if (lpSync_reg[1] == lpSync_reg[2])
				lpLevel_reg <= lpSync_reg[2];
			if (frSync_reg[1] == frSync_reg[2])
				frLevel_reg <= frSync_reg[2];
		end
	end

	always_comb
	begin
		case (cfg_reg.runClockSourceSelect)
			WCD_SRC_LOW_POWER_RC: srcTick = risenOf(lpSync_reg, lpLevel_reg);
			WCD_SRC_FAST_RC: srcTick = risenOf(frSync_reg, frLevel_reg);
			WCD_SRC_SYSTEM: srcTick = 1'b1;
			default: srcTick = 1'b0;
		endcase
	end

	assign watchdogRunning = cfgLoaded_reg & cfg_reg.watchdogEnableFuse;
	assign terminal = termOf(cfg_reg.runPostscaleSelect);
	assign wrAccess = psel & penable & pwrite;
	assign service = wrAccess && paddr == WCD_OFS_SERVICE && pwdata == WCD_SERVICE_KEY && watchdogRunning;
	assign early = service && !cfg_reg.windowModeDisable && postCount_reg < (terminal >> 1);
	assign expire = watchdogRunning && srcTick && postCount_reg == terminal && !service;

	// Postscaled watchdog counter
	always_ff @(posedge clock or negedge rstSync_n)
	begin
		if (!rstSync_n)
			postCount_reg <= 20'h0;
		else if (!watchdogRunning || service || expire)
			postCount_reg <= 20'h0;
		else if (srcTick)
			postCount_reg <= postCount_reg + WCD_TERM_ONE;
	end

	always_ff @(posedge clock or negedge rstSync_n)
	begin
		if (!rstSync_n)
			timeout_reg <= 1'b0;
		else
			timeout_reg <= expire | early;
	end
	assign timeoutPulse = timeout_reg;

	// Sticky timeout and early flags, write one to clear, a new event wins; running follows the live level
	always_ff @(posedge clock or negedge rstSync_n)
	begin
		if (!rstSync_n)
			status_reg <= '0;
		else
		begin
			status_reg.running <= watchdogRunning;
			if (expire | early)
				status_reg.timeout <= 1'b1;
			else if (wrAccess && paddr == WCD_OFS_STATUS && pwdata[WCD_STAT_TIMEOUT])
				status_reg.timeout <= 1'b0;
			if (early)
				status_reg.early <= 1'b1;
			else if (wrAccess && paddr == WCD_OFS_STATUS && pwdata[WCD_STAT_EARLY])
				status_reg.early <= 1'b0;
		end
	end

	always_comb
	begin
		readData = 32'h0;
		case (paddr)
			WCD_OFS_CONFIG: readData = {16'hffff, cfg_reg};
			WCD_OFS_STATUS: readData = {29'h0, status_reg};
			WCD_OFS_COUNT: readData = {12'h0, postCount_reg};
			default: readData = 32'h0;
		endcase
	end

	always_ff @(posedge clock or negedge rstSync_n)
	begin
		if (!rstSync_n)
			prdata_reg <= 32'h0;
		else if (psel && !penable && !pwrite)
			prdata_reg <= readData;
	end
	assign prdata = prdata_reg;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped(paddr);

	sequence sExpiry;
		watchdogRunning && srcTick && postCount_reg == terminal && !service;
	endsequence

	sequence sEarlyService;
		service && !cfg_reg.windowModeDisable && postCount_reg < (terminal >> 1);
	endsequence

	a_run_follows_fuse: assert property (@(posedge clock) disable iff (!rstSync_n)
		$rose(cfgLoaded_reg) |-> watchdogRunning == $past(configWord[WCD_POS_ENABLE]))
		else $error("Running level differs from enable fuse");

	a_stopped_idle: assert property (@(posedge clock) disable iff (!rstSync_n)
		!watchdogRunning |=> postCount_reg == 20'h0 && !timeoutPulse)
		else $error("Stopped watchdog counted or timed out");

	a_src_reserved: assert property (@(posedge clock) disable iff (!rstSync_n)
		cfg_reg.runClockSourceSelect == WCD_SRC_RESERVED |-> !srcTick)
		else $error("Reserved source produced a tick");

	a_src_system: assert property (@(posedge clock) disable iff (!rstSync_n)
		watchdogRunning && cfg_reg.runClockSourceSelect == WCD_SRC_SYSTEM && !service && !expire
		|=> postCount_reg == $past(postCount_reg) + WCD_TERM_ONE)
		else $error("System clock source did not advance counter");

	a_post_ratio: assert property (@(posedge clock) disable iff (!rstSync_n)
		cfg_reg.runPostscaleSelect < WCD_POST_SAT_CODE |-> terminal + WCD_TERM_ONE == 20'(21'h1 << cfg_reg.runPostscaleSelect))
		else $error("Postscale ratio wrong");

	a_post_saturate: assert property (@(posedge clock) disable iff (!rstSync_n)
		cfg_reg.runPostscaleSelect >= WCD_POST_SAT_CODE |-> terminal == WCD_TERM_MAX)
		else $error("Postscale did not saturate");

	a_window_early: assert property (@(posedge clock) disable iff (!rstSync_n)
		sEarlyService |=> timeoutPulse && status_reg.early && status_reg.timeout)
		else $error("Early service in windowed mode not flagged");

	a_window_off: assert property (@(posedge clock) disable iff (!rstSync_n)
		service && cfg_reg.windowModeDisable |=> postCount_reg == 20'h0 && !status_reg.early)
		else $error("Non-windowed service misbehaved");

	a_field_capture: assert property (@(posedge clock) disable iff (!rstSync_n)
		$rose(cfgLoaded_reg) |-> cfg_reg.runPostscaleSelect == $past(configWord[WCD_POS_RUNPOST_HI:WCD_POS_RUNPOST_LO])
			&& cfg_reg.runClockSourceSelect == $past(configWord[WCD_POS_RUNCLK_HI:WCD_POS_RUNCLK_LO]))
		else $error("Configuration fields misplaced");

	a_expire_timeout: assert property (@(posedge clock) disable iff (!rstSync_n)
		sExpiry |=> timeoutPulse && postCount_reg == 20'h0 && status_reg.timeout)
		else $error("Expiry did not raise timeout");
endmodule

// ---- common/wcd_pkg.sv ----
/*
 Package for the watchdog configuration decoder: register offsets, field positions,
 codes and the decoded configuration record.
 Assumes a 32-bit APB register bus and a configuration word held steady from reset.
*/
package wcd_pkg;
	localparam logic [7:0] WCD_OFS_CONFIG = 8'h00;
	localparam logic [7:0] WCD_OFS_SERVICE = 8'h04;
	localparam logic [7:0] WCD_OFS_STATUS = 8'h08;
	localparam logic [7:0] WCD_OFS_COUNT = 8'h0c;
	localparam logic [31:0] WCD_SERVICE_KEY = 32'h0000_5a5a;
	localparam int WCD_POS_ENABLE = 15;
	localparam int WCD_POS_RUNCLK_HI = 14;
	localparam int WCD_POS_RUNCLK_LO = 13;
	localparam int WCD_POS_RUNPOST_HI = 12;
	localparam int WCD_POS_RUNPOST_LO = 8;
	localparam int WCD_POS_WINDOW_MODE_DISABLE = 7;
	localparam int WCD_POS_WINSIZE_HI = 6;
	localparam int WCD_POS_WINSIZE_LO = 5;
	localparam int WCD_POS_SLPPOST_HI = 4;
	localparam int WCD_POS_SLPPOST_LO = 0;
	localparam int WCD_STAT_TIMEOUT = 0;
	localparam int WCD_STAT_EARLY = 1;
	localparam int WCD_STAT_RUNNING = 2;
	localparam logic [1:0] WCD_SRC_SYSTEM = 2'h0;
	localparam logic [1:0] WCD_SRC_RESERVED = 2'h1;
	localparam logic [1:0] WCD_SRC_FAST_RC = 2'h2;
	localparam logic [1:0] WCD_SRC_LOW_POWER_RC = 2'h3;
	localparam logic [4:0] WCD_POST_SAT_CODE = 5'h14;
	localparam logic [19:0] WCD_TERM_MAX = 20'hfffff;
	localparam logic [19:0] WCD_TERM_ONE = 20'h00001;

	typedef struct packed {
		logic watchdogEnableFuse;
		logic [1:0] runClockSourceSelect;
		logic [4:0] runPostscaleSelect;
		logic windowModeDisable;
		logic [1:0] windowSizeSelect;
		logic [4:0] sleepPostscaleSelect;
	} wcd_cfg_t;

	typedef struct packed {
		logic running;
		logic early;
		logic timeout;
	} wcd_status_t;
endpackage

// ---- dv/test_watchdog_config_decode.sv ----
/*
 Testbench for the watchdog configuration decoder: APB tasks and directed tests.
 Assumes wcd_pkg is compiled first and the slave answers APB with no wait states.
*/
`timescale 1ns/1ps
module test_watchdog_config_decode
	import wcd_pkg::*;
;
	logic clock, rst_n, psel, penable, pwrite, lowPowerRcPin, fastRcPin, pready, pslverr;
	logic timeoutPulse, watchdogRunning, lastErr;
	logic [7:0] paddr;
	logic [31:0] configWord, pwdata, prdata;
	int err_total, checks_done, n, i, fc, lc;
	logic [1:0] srcT [5] = '{2'h0, 2'h0, 2'h2, 2'h3, 2'h0};
	logic [4:0] posT [5] = '{5'h00, 5'h03, 5'h02, 5'h01, 5'h06};
	int expT [5] = '{1, 8, 24, 28, 64};

	wcd_watchdog DUT (.clock(clock), .rst_n(rst_n), .configWord(configWord), .lowPowerRcPin(lowPowerRcPin),
		.fastRcPin(fastRcPin), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .timeoutPulse(timeoutPulse),
		.watchdogRunning(watchdogRunning));

	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// Oscillator pins: fast RC period 6 cycles, low-power RC period 14 cycles
	always @(posedge clock)
	begin
		fc <= (fc == 2) ? 0 : fc + 1;
		lc <= (lc == 6) ? 0 : lc + 1;
		if (fc == 2) fastRcPin <= ~fastRcPin;
		if (lc == 6) lowPowerRcPin <= ~lowPowerRcPin;
	end

	task automatic print_verdict();
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic tick();
		@(posedge clock);
		#1;
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		int k;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge clock);
			k++;
		end
		while (pready !== 1'b1 && k < 50);
		if (pready !== 1'b1)
		begin
			err_total++;
			print_verdict();
		end
		r = prdata;
		lastErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(1'b1, a, d, r);
	endtask

	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		apb(1'b0, a, 32'h0, r);
		chk(nm, e, r);
	endtask

	task automatic rst(input logic [15:0] w);
		@(posedge clock);
		rst_n <= 1'b0;
		configWord <= {16'hffff, w};
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		repeat (6) @(posedge clock);
	endtask

	// Cycles between two timeout pulses
	task automatic gap(output int g);
		int k;
		g = 0;
		for (k = 0; k < 30000 && timeoutPulse !== 1'b1; k++) tick();
		do
		begin
			tick();
			g++;
		end
		while (g < 30000 && timeoutPulse !== 1'b1);
		if (g >= 30000)
		begin
			err_total++;
			print_verdict();
		end
	endtask

	initial
	begin
		err_total = 0;
		checks_done = 0;
		{psel, penable, pwrite, paddr, pwdata, rst_n, fastRcPin, lowPowerRcPin, fc, lc} = '0;
		configWord = '1;
		rst(16'hd535);
		rdc("config", WCD_OFS_CONFIG, 32'hffffd535);
		rdc("unmapped", 8'h10, 32'h0);
		chk("slverr", 32'h1, {31'h0, lastErr});
		rst(16'h0380);
		repeat (100) tick();
		chk("running", 32'h0, {31'h0, watchdogRunning});
		rdc("count off", WCD_OFS_COUNT, 32'h0);
		for (i = 0; i < 5; i++)
		begin
			rst({1'b1, srcT[i], posT[i], 1'b1, 7'h00});
			gap(n);
			chk("interval", expT[i], 32'(n));
		end
		rst({1'b1, 2'h1, 5'h00, 1'b1, 7'h00});
		repeat (50) tick();
		rdc("count frozen", WCD_OFS_COUNT, 32'h0);
		rdc("frozen status", WCD_OFS_STATUS, 32'h4);
		rst({1'b1, 2'h0, 5'h14, 1'b1, 7'h00});
		repeat (2000) tick();
		rdc("sat lo", WCD_OFS_STATUS, 32'h4);
		rst({1'b1, 2'h0, 5'h1f, 1'b1, 7'h00});
		repeat (2000) tick();
		rdc("sat hi", WCD_OFS_STATUS, 32'h4);
		rst({1'b1, 2'h0, 5'h06, 1'b0, 7'h00});
		wr(WCD_OFS_SERVICE, WCD_SERVICE_KEY);
		rdc("early", WCD_OFS_STATUS, 32'h7);
		wr(WCD_OFS_STATUS, 32'h2);
		rdc("early clr", WCD_OFS_STATUS, 32'h5);
		rst({1'b1, 2'h0, 5'h06, 1'b1, 7'h00});
		repeat (10)
		begin
			repeat (30) tick();
			wr(WCD_OFS_SERVICE, WCD_SERVICE_KEY);
		end
		rdc("serviced", WCD_OFS_STATUS, 32'h4);
		gap(n);
		chk("expiry", 32'd64, 32'(n));
		rdc("timeout", WCD_OFS_STATUS, 32'h5);
		print_verdict();
	end
endmodule
